// file: mcms_pkg.sv
package mcms_pkg;

	// measurement functions, in the host's selection order
	typedef enum logic [3:0] {
		FN_DCV,
		FN_RATIO,
		FN_ACV,
		FN_DCI,
		FN_ACI,
		FN_OHM2,
		FN_OHM4,
		FN_FREQ,
		FN_PER,
		FN_CONT,
		FN_DIODE
	} mcms_func_e;

	// math operations
	typedef enum logic [2:0] {
		OP_NULL,
		OP_DB,
		OP_POWER_DECIBEL,
		OP_MIN_MAX,
		OP_LIMIT_TEST
	} mcms_op_e;

	// register byte offsets
	localparam logic [5:0] REG_FUNC = 6'h00;
	localparam logic [5:0] REG_CONF = 6'h04;
	localparam logic [5:0] REG_RANGE = 6'h08;
	localparam logic [5:0] REG_AUTORANGE = 6'h0C;
	localparam logic [5:0] REG_RES = 6'h10;
	localparam logic [5:0] REG_INTEG = 6'h14;
	localparam logic [5:0] REG_GATE_FREQ = 6'h18;
	localparam logic [5:0] REG_GATE_PER = 6'h1C;
	localparam logic [5:0] REG_AC_FILTER = 6'h20;
	localparam logic [5:0] REG_ZERO = 6'h24;
	localparam logic [5:0] REG_INPUT_R = 6'h28;
	localparam logic [5:0] REG_MATH_FUNC = 6'h2C;
	localparam logic [5:0] REG_MATH_STATE = 6'h30;
	localparam logic [5:0] REG_STATUS = 6'h34;
	localparam logic [5:0] REG_RESET = 6'h38;

	// status field positions
	localparam int ERR_CONFLICT = 0;
	localparam int ERR_REJECT = 1;
	localparam int ERR_BAD = 2;
	localparam int ST_ZERO_RPT = 8;
	localparam int ST_HIGHZ = 9;
	localparam int ST_TEST_CUR = 10;

	// range indices
	localparam logic [2:0] RMAX_VOLT = 3'h4;
	localparam logic [2:0] RMAX_CURR = 3'h3;
	localparam logic [2:0] RMAX_OHM = 3'h6;
	localparam logic [2:0] RANGE_1K = 3'h1;
	localparam logic [2:0] RANGE_1V = 3'h1;
	localparam logic [2:0] RANGE_HIGHZ_TOP = 3'h2;
	localparam logic [7:0] RANGE_MAX_CODE = 8'hFF;

	// autorange thresholds in percent of range
	localparam logic [7:0] AR_DOWN_PCT = 8'h0A;
	localparam logic [7:0] AR_UP_PCT = 8'h78;

	// resolution values, in measurement units
	localparam logic [31:0] RES_DEFAULT = 32'h0000_0064;
	localparam logic [31:0] RES_FINEST = 32'h0000_0001;
	localparam logic [31:0] RES_COARSEST = 32'h0000_2710;
	localparam logic [31:0] RES_MIN_CODE = 32'h0000_0000;
	localparam logic [31:0] RES_MAX_CODE = 32'hFFFF_FFFF;
	localparam logic [31:0] RES_3HZ_GATE0 = 32'h0000_03E8;
	localparam logic [31:0] RES_3HZ_GATE1 = 32'h0000_0064;
	localparam logic [31:0] RES_3HZ_GATE2 = 32'h0000_000A;

	// integration codes: 0.02, 0.2, 1, 10, 100 line cycles
	localparam logic [2:0] INTEG_MAX = 3'h4;
	localparam logic [2:0] INTEG_DEFAULT = 3'h3;

	// gate codes: 10 ms, 100 ms, 1 s
	localparam logic [1:0] GATE_MAX = 2'h2;
	localparam logic [1:0] GATE_DEFAULT = 2'h1;

	// ac filter codes and their lowest input frequency in Hz
	localparam logic [1:0] ACF_SLOW = 2'h0;
	localparam logic [1:0] ACF_MED = 2'h1;
	localparam logic [1:0] ACF_FAST = 2'h2;
	localparam logic [31:0] ACF_SLOW_HZ = 32'h0000_0003;
	localparam logic [31:0] ACF_MED_HZ = 32'h0000_0014;
	localparam logic [31:0] ACF_FAST_HZ = 32'h0000_00C8;

	// autozero write codes
	localparam logic [1:0] AZ_OFF = 2'h0;
	localparam logic [1:0] AZ_ON = 2'h1;
	localparam logic [1:0] AZ_ONE_SHOT = 2'h2;

	function automatic logic [2:0] mcms_range_max(input mcms_func_e f);
		case (f)
			FN_DCI, FN_ACI: return RMAX_CURR;
			FN_OHM2, FN_OHM4: return RMAX_OHM;
			FN_CONT, FN_DIODE: return 3'h0;
			default: return RMAX_VOLT;
		endcase
	endfunction : mcms_range_max

endpackage : mcms_pkg

// file: mcms_math_check.sv
`timescale 1ns/100ps
module mcms_math_check
	import mcms_pkg::*;
(
	// pairing under test
	input mcms_func_e func_in,
	input mcms_op_e op_in,
	// verdict
	output logic allowed_out
);

	always_comb begin
		allowed_out = 1'b0;
		case (op_in)
			OP_NULL: allowed_out = !(func_in inside {FN_CONT, FN_DIODE,
				FN_RATIO}); // [RQ17]
			OP_MIN_MAX, OP_LIMIT_TEST: allowed_out =
				!(func_in inside {FN_CONT, FN_DIODE}); // [RQ17]
			OP_DB, OP_POWER_DECIBEL: allowed_out =
				(func_in inside {FN_DCV, FN_ACV}); // [RQ17]
			default: allowed_out = 1'b0;
		endcase
	end

endmodule : mcms_math_check

// file: mcms_autorange.sv
`timescale 1ns/100ps
module mcms_autorange
	import mcms_pkg::*;
#(
	parameter int PCT_W = 8
)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// reading and range
	input wire logic enable_in,
	input wire logic valid_in,
	input wire logic [PCT_W-1:0] pct_in,
	input wire logic [2:0] range_in,
	input wire logic [2:0] range_max_in,
	// one-cycle step requests
	output logic step_up_out,
	output logic step_down_out
);

	typedef struct packed {
		logic up;
		logic down;
	} mcms_ar_s;

	mcms_ar_s r;
	mcms_ar_s next_r;

	always_comb begin
		next_r.up = enable_in & valid_in & (pct_in > PCT_W'(AR_UP_PCT))
			& (range_in < range_max_in); // [RQ7]
		next_r.down = enable_in & valid_in
			& (pct_in < PCT_W'(AR_DOWN_PCT))
			& (range_in != 3'h0); // [RQ7]
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign step_up_out = r.up;
	assign step_down_out = r.down;

endmodule : mcms_autorange

// file: mcms_config.sv
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
// Function
// RQ1 - configure presets the function and leaves the trigger system idle
// RQ2 - frequency and period use one range; no input reports zero
// RQ3 - continuity forces 1 kohm range, 5.5 digits, ignores range/res writes
// RQ4 - diode forces 1 V range, 1 mA source, 5.5 digits
// RQ5 - host names function; device takes eleven codes and reports it
// RQ6 - range acts on present function; min lowest, max highest
// RQ7 - autorange steps down below 10% and up above 120%; reads 0/1
// RQ8 - resolution in units; rejected in frequency, period and ratio
// RQ9 - resolution read in frequency or period assumes a 3 Hz input
// RQ10 - integration 0.02 to 100 cycles, default 10, dc functions only
// RQ11 - gate times 10 ms, 100 ms default, 1 s for frequency and period
// RQ12 - ac filter from 3, 20 or 200 Hz; medium by default
// RQ13 - autozero off zeroes only at next wait-for-trigger entry; on default; the code zeroes at every wait-for-trigger entry while off
// RQ14 - one-shot zeroes at one_shot_zero then acts as off; reads 0 or 1
// RQ15 - auto input resistance high on 100 mV to 10 V; off by default
// RQ16 - one math op at a time; off on disable, function change, reset
// RQ17 - allowed math operations depend on the measurement function
// RQ18 - selecting a disallowed math operation turns math off
// RQ19 - valid operation replaced by invalid raises settings conflict
// RQ20 - host enables math before writing its reference registers
// RQ21 - math selector defaults to null and reads one of five ops
// RQ22 - math enable switches the operation; reads 0 or 1
// RQ23 - power-up or remote reset restores every default
module mcms_config
	import mcms_pkg::*;
#(
	parameter int PCT_W = 8
)
(
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RST_B_IN,
	// avalon-mm slave
	input wire logic [5:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	// measurement feedback
	input wire logic READING_VALID_IN,
	input wire logic [PCT_W-1:0] READING_PCT_IN,
	input wire logic WAIT_TRIG_ENTRY_IN,
	input wire logic SIGNAL_PRESENT_IN,
	// configuration to the front end
	output logic [3:0] FUNC_OUT,
	output logic [2:0] RANGE_OUT,
	output logic AUTORANGE_OUT,
	output logic [31:0] RES_OUT,
	output logic [2:0] INTEG_OUT,
	output logic [1:0] GATE_FREQ_OUT,
	output logic [1:0] GATE_PER_OUT,
	output logic [1:0] AC_FILTER_OUT,
	output logic AUTOZERO_OUT,
	output logic ZERO_REQ_OUT,
	output logic INPUT_HIGHZ_OUT,
	output logic TEST_CURRENT_OUT,
	output logic REPORT_ZERO_OUT,
	output logic TRIG_IDLE_OUT,
	// math selection
	output logic [2:0] MATH_OP_OUT,
	output logic MATH_ON_OUT
);

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		mcms_func_e func;
		logic [2:0] range;
		logic autorange;
		logic [31:0] res;
		logic [2:0] integ;
		logic [1:0] gate_freq;
		logic [1:0] gate_per;
		logic [1:0] ac_filter;
		logic autozero;
		logic zero_req;
		logic auto_input_r;
		mcms_op_e op;
		logic math_on;
		logic [2:0] err;
		logic trig_idle;
		logic sig_s1;
		logic sig_s2;
		logic [2:0] o_range;
		logic o_autorange;
		logic o_highz;
		logic o_test_cur;
		logic o_zero_rpt;
	} mcms_state_s;

	mcms_state_s r;
	mcms_state_s next_r;

	logic req;
	logic wr_take;
	logic full_word;
	logic [31:0] wd;
	logic fixed;
	logic [2:0] rmax;
	logic new_ok;
	logic cur_ok;
	logic step_up;
	logic step_down;

	assign req = AVS_READ_IN | AVS_WRITE_IN;
	assign wr_take = AVS_WRITE_IN & r.ack;
	assign full_word = (AVS_BYTEENABLE_IN == 4'hF);
	assign wd = AVS_WRITEDATA_IN;
	assign fixed = (r.func == FN_CONT) || (r.func == FN_DIODE);
	assign rmax = mcms_range_max(r.func);

	mcms_math_check u_check_new (
		.func_in(r.func),
		.op_in(mcms_op_e'(wd[2:0])),
		.allowed_out(new_ok)
	);

	mcms_math_check u_check_cur (
		.func_in(r.func),
		.op_in(r.op),
		.allowed_out(cur_ok)
	);

	mcms_autorange #(
		.PCT_W(PCT_W)
	) u_autorange (
		.clk_in(CLOCK_IN),
		.rst_b_in(RST_B_IN),
		.enable_in(r.autorange & ~fixed),
		.valid_in(READING_VALID_IN),
		.pct_in(READING_PCT_IN),
		.range_in(r.range),
		.range_max_in(rmax),
		.step_up_out(step_up),
		.step_down_out(step_down)
	);

	// every volatile setting at its default
	function automatic mcms_state_s cfg_default(input mcms_state_s s);
		mcms_state_s d;
		d = s;
		d.func = FN_DCV;
		d.range = RMAX_VOLT;
		d.autorange = 1'b1;
		d.res = RES_DEFAULT;
		d.integ = INTEG_DEFAULT;
		d.gate_freq = GATE_DEFAULT;
		d.gate_per = GATE_DEFAULT;
		d.ac_filter = ACF_MED;
		d.autozero = 1'b1;
		d.zero_req = 1'b0;
		d.auto_input_r = 1'b0;
		d.op = OP_NULL;
		d.math_on = 1'b0;
		d.err = 3'h0;
		d.trig_idle = 1'b1;
		return d;
	endfunction : cfg_default

	// preset for a newly chosen function, no measurement started
	function automatic mcms_state_s cfg_preset(input mcms_state_s s,
		input mcms_func_e f);
		mcms_state_s d;
		d = s;
		d.func = f;
		d.range = mcms_range_max(f);
		d.autorange = 1'b1;
		d.res = RES_DEFAULT;
		d.integ = INTEG_DEFAULT;
		d.math_on = 1'b0;
		d.trig_idle = 1'b1;
		return d;
	endfunction : cfg_preset

	always_comb begin
		logic [31:0] rd;
		rd = 32'h0;
		next_r = r;
		next_r.zero_req = 1'b0;
		next_r.sig_s1 = SIGNAL_PRESENT_IN;
		next_r.sig_s2 = r.sig_s1;
		next_r.ack = req & ~r.ack;

		// read mux
		case (AVS_ADDRESS_IN)
			REG_FUNC, REG_CONF: rd = {28'h0, r.func}; // [RQ5]
			REG_RANGE: rd = {29'h0, r.o_range};
			REG_AUTORANGE: rd = {31'h0, r.o_autorange}; // [RQ7]
			REG_RES: begin
				if (r.func == FN_FREQ || r.func == FN_PER) begin
					case (r.func == FN_FREQ ? r.gate_freq : r.gate_per)
						2'h0: rd = RES_3HZ_GATE0; // [RQ9]
						2'h1: rd = RES_3HZ_GATE1; // [RQ9]
						default: rd = RES_3HZ_GATE2; // [RQ9]
					endcase
				end else begin
					rd = r.res;
				end
			end
			REG_INTEG: rd = {29'h0, r.integ};
			REG_GATE_FREQ: rd = {30'h0, r.gate_freq};
			REG_GATE_PER: rd = {30'h0, r.gate_per};
			REG_AC_FILTER: begin
				case (r.ac_filter)
					ACF_SLOW: rd = ACF_SLOW_HZ; // [RQ12]
					ACF_FAST: rd = ACF_FAST_HZ; // [RQ12]
					default: rd = ACF_MED_HZ; // [RQ12]
				endcase
			end
			REG_ZERO: rd = {31'h0, r.autozero}; // [RQ14]
			REG_INPUT_R: rd = {31'h0, r.auto_input_r}; // [RQ15]
			REG_MATH_FUNC: rd = {29'h0, r.op}; // [RQ21]
			REG_MATH_STATE: rd = {31'h0, r.math_on}; // [RQ22]
			REG_STATUS: begin
				rd[2:0] = r.err;
				rd[ST_ZERO_RPT] = r.o_zero_rpt;
				rd[ST_HIGHZ] = r.o_highz;
				rd[ST_TEST_CUR] = r.o_test_cur;
			end
			default: rd = 32'h0;
		endcase
		if (req & ~r.ack & AVS_READ_IN) begin
			next_r.rdata = rd;
		end

		// range stepping from the reading level
		if (step_up) begin
			next_r.range = r.range + 3'h1; // [RQ7]
		end else if (step_down) begin
			next_r.range = r.range - 3'h1; // [RQ7]
		end

		// zero measurement at wait-for-trigger entry while off
		if (!r.autozero && WAIT_TRIG_ENTRY_IN) begin
			next_r.zero_req = 1'b1; // [RQ13]
		end
		if (WAIT_TRIG_ENTRY_IN) begin
			next_r.trig_idle = 1'b0;
		end

		if (wr_take && !full_word) begin
			next_r.err[ERR_BAD] = 1'b1;
		end else if (wr_take) begin
			case (AVS_ADDRESS_IN)
				REG_FUNC, REG_CONF: begin
					if (wd[3:0] > FN_DIODE) begin
						next_r.err[ERR_BAD] = 1'b1;
					end else if (AVS_ADDRESS_IN == REG_CONF) begin
						next_r = cfg_preset(next_r,
							mcms_func_e'(wd[3:0])); // [RQ1] [RQ5] [RQ16]
					end else begin
						next_r.func = mcms_func_e'(wd[3:0]); // [RQ5]
						next_r.range = mcms_range_max(
							mcms_func_e'(wd[3:0]));
						next_r.math_on = 1'b0; // [RQ16]
					end
				end
				REG_RANGE: begin
					if (fixed) begin
						next_r.range = r.range; // [RQ3]
					end else if (wd[7:0] == RANGE_MAX_CODE) begin
						next_r.range = rmax; // [RQ6]
					end else if (wd[31:3] != 29'h0 || wd[2:0] > rmax) begin
						next_r.err[ERR_BAD] = 1'b1;
					end else begin
						next_r.range = wd[2:0]; // [RQ6] [RQ2]
					end
				end
				REG_AUTORANGE: next_r.autorange = wd[0]; // [RQ7]
				REG_RES: begin
					if (r.func inside {FN_FREQ, FN_PER, FN_RATIO}) begin
						next_r.err[ERR_REJECT] = 1'b1; // [RQ8]
					end else if (fixed) begin
						next_r.res = r.res; // [RQ3]
					end else if (wd == RES_MIN_CODE) begin
						next_r.res = RES_FINEST; // [RQ8]
					end else if (wd == RES_MAX_CODE) begin
						next_r.res = RES_COARSEST; // [RQ8]
					end else begin
						next_r.res = wd; // [RQ8]
					end
				end
				REG_INTEG: begin
					if (!(r.func inside {FN_DCV, FN_RATIO, FN_DCI,
						FN_OHM2, FN_OHM4})) begin
						next_r.err[ERR_REJECT] = 1'b1; // [RQ10]
					end else if (wd > {29'h0, INTEG_MAX}) begin
						next_r.err[ERR_BAD] = 1'b1;
					end else begin
						next_r.integ = wd[2:0]; // [RQ10]
					end
				end
				REG_GATE_FREQ, REG_GATE_PER: begin
					if (wd > {30'h0, GATE_MAX}) begin
						next_r.err[ERR_BAD] = 1'b1;
					end else if (AVS_ADDRESS_IN == REG_GATE_FREQ) begin
						next_r.gate_freq = wd[1:0]; // [RQ11]
					end else begin
						next_r.gate_per = wd[1:0]; // [RQ11]
					end
				end
				REG_AC_FILTER: begin
					if (wd == ACF_SLOW_HZ) begin
						next_r.ac_filter = ACF_SLOW; // [RQ12]
					end else if (wd == ACF_MED_HZ) begin
						next_r.ac_filter = ACF_MED; // [RQ12]
					end else if (wd == ACF_FAST_HZ) begin
						next_r.ac_filter = ACF_FAST; // [RQ12]
					end else begin
						next_r.err[ERR_BAD] = 1'b1;
					end
				end
				REG_ZERO: begin
					case (wd[1:0])
						AZ_OFF: next_r.autozero = 1'b0; // [RQ13]
						AZ_ON: next_r.autozero = 1'b1;
						AZ_ONE_SHOT: begin
							next_r.autozero = 1'b0; // [RQ14]
							next_r.zero_req = 1'b1; // [RQ14]
						end
						default: next_r.err[ERR_BAD] = 1'b1;
					endcase
				end
				REG_INPUT_R: next_r.auto_input_r = wd[0]; // [RQ15]
				REG_MATH_FUNC: begin
					if (wd[2:0] > OP_LIMIT_TEST || wd[31:3] != 29'h0) begin
						next_r.err[ERR_BAD] = 1'b1;
					end else begin
						next_r.op = mcms_op_e'(wd[2:0]); // [RQ16]
						if (!new_ok) begin
							if (r.math_on && cur_ok) begin
								next_r.err[ERR_CONFLICT] = 1'b1; // [RQ19]
							end
							next_r.math_on = 1'b0; // [RQ18]
						end
					end
				end
				REG_MATH_STATE: next_r.math_on = wd[0] & cur_ok; // [RQ22]
				REG_STATUS: next_r.err = r.err & ~wd[2:0];
				REG_RESET: begin
					if (wd[0]) begin
						next_r = cfg_default(next_r); // [RQ23]
					end
				end
				default: next_r.err = r.err;
			endcase
		end

		// forced settings and derived outputs
		if (next_r.func == FN_CONT) begin
			next_r.o_range = RANGE_1K; // [RQ3]
			next_r.res = RES_DEFAULT; // [RQ3]
		end else if (next_r.func == FN_DIODE) begin
			next_r.o_range = RANGE_1V; // [RQ4]
			next_r.res = RES_DEFAULT; // [RQ4]
		end else begin
			next_r.o_range = next_r.range;
		end
		next_r.o_autorange = next_r.autorange
			& !(next_r.func inside {FN_CONT, FN_DIODE});
		next_r.o_test_cur = (next_r.func == FN_DIODE); // [RQ4]
		next_r.o_highz = next_r.auto_input_r
			&& (next_r.func == FN_DCV)
			&& (next_r.range <= RANGE_HIGHZ_TOP); // [RQ15]
		next_r.o_zero_rpt = (next_r.func inside {FN_FREQ, FN_PER})
			& ~r.sig_s2; // [RQ2]
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			r <= '0;
			r.range <= RMAX_VOLT; // [RQ23]
			r.o_range <= RMAX_VOLT;
			r.autorange <= 1'b1;
			r.o_autorange <= 1'b1;
			r.res <= RES_DEFAULT;
			r.integ <= INTEG_DEFAULT;
			r.gate_freq <= GATE_DEFAULT;
			r.gate_per <= GATE_DEFAULT;
			r.ac_filter <= ACF_MED;
			r.autozero <= 1'b1;
			r.trig_idle <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign AVS_WAITREQUEST_OUT = req & ~r.ack;
	assign AVS_READDATA_OUT = r.rdata;
	assign FUNC_OUT = r.func;
	assign RANGE_OUT = r.o_range;
	assign AUTORANGE_OUT = r.o_autorange;
	assign RES_OUT = r.res;
	assign INTEG_OUT = r.integ;
	assign GATE_FREQ_OUT = r.gate_freq;
	assign GATE_PER_OUT = r.gate_per;
	assign AC_FILTER_OUT = r.ac_filter;
	assign AUTOZERO_OUT = r.autozero;
	assign ZERO_REQ_OUT = r.zero_req;
	assign INPUT_HIGHZ_OUT = r.o_highz;
	assign TEST_CURRENT_OUT = r.o_test_cur;
	assign REPORT_ZERO_OUT = r.o_zero_rpt;
	assign TRIG_IDLE_OUT = r.trig_idle;
	assign MATH_OP_OUT = r.op;
	assign MATH_ON_OUT = r.math_on;

endmodule : mcms_config

// file: mcms_expect.svh
// largest range index of a function; fixed-range functions report 1
function automatic logic [2:0] xp_rmax(input logic [3:0] f);
	case (f)
		4'h3, 4'h4: return 3'h3;
		4'h5, 4'h6: return 3'h6;
		4'h9, 4'hA: return 3'h1;
		default: return 3'h4;
	endcase
endfunction : xp_rmax

// whether a math operation may run with a function
function automatic logic xp_ok(input logic [3:0] f, input logic [2:0] o);
	case (o)
		3'h0: return f < 4'h9 && f != 4'h1;
		3'h1, 3'h2: return f == 4'h0 || f == 4'h2;
		3'h3, 3'h4: return f < 4'h9;
		default: return 1'b0;
	endcase
endfunction : xp_ok

// file: mcms_config_asserts.sv
`timescale 1ns/100ps
module mcms_config_asserts
	import mcms_pkg::*;
#(
	parameter int PCT_W = 8
)
(
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RST_B_IN,
	// bus
	input wire logic [5:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	input wire logic AVS_WAITREQUEST_OUT,
	// measurement feedback
	input wire logic READING_VALID_IN,
	input wire logic [PCT_W-1:0] READING_PCT_IN,
	input wire logic WAIT_TRIG_ENTRY_IN,
	// configuration
	input wire logic [3:0] FUNC_OUT,
	input wire logic [2:0] RANGE_OUT,
	input wire logic AUTORANGE_OUT,
	input wire logic [2:0] INTEG_OUT,
	input wire logic AUTOZERO_OUT,
	input wire logic ZERO_REQ_OUT,
	input wire logic INPUT_HIGHZ_OUT,
	input wire logic TEST_CURRENT_OUT,
	input wire logic REPORT_ZERO_OUT,
	input wire logic TRIG_IDLE_OUT,
	input wire logic [2:0] MATH_OP_OUT,
	input wire logic MATH_ON_OUT
);
	`include "mcms_expect.svh"
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_B_IN);
	chk_wait_one: assert property ((AVS_READ_IN || AVS_WRITE_IN) &&
		AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
		else $error("waitrequest longer than one cycle");
	chk_cont_fixed: assert property (
		FUNC_OUT == 4'h9 && $past(FUNC_OUT) == 4'h9 |->
		RANGE_OUT == RANGE_1K && !AUTORANGE_OUT)
		else $error("continuity range not fixed");
	chk_diode_fixed: assert property (
		FUNC_OUT == 4'hA && $past(FUNC_OUT) == 4'hA |->
		RANGE_OUT == RANGE_1V && TEST_CURRENT_OUT)
		else $error("diode range or source wrong");
	chk_func_clears: assert property ($changed(FUNC_OUT) |->
		##[0:1] !MATH_ON_OUT) else $error("math kept over function change");
	chk_math_allowed: assert property (MATH_ON_OUT &&
		$stable(FUNC_OUT) && $stable(MATH_OP_OUT) |->
		xp_ok(FUNC_OUT, MATH_OP_OUT)) else $error("math on with bad op");
	chk_zero_off: assert property (
		WAIT_TRIG_ENTRY_IN && !AUTOZERO_OUT |=> ZERO_REQ_OUT)
		else $error("no zero at wait-for-trigger entry");
	chk_one_shot_zero_off: assert property (
		ZERO_REQ_OUT && !$past(WAIT_TRIG_ENTRY_IN) |->
		##[0:1] !AUTOZERO_OUT ##1 !ZERO_REQ_OUT)
		else $error("one-shot zero left autozero on");
	chk_conf_preset: assert property (
		AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == REG_CONF &&
		AVS_BYTEENABLE_IN == 4'hF |=> TRIG_IDLE_OUT && !MATH_ON_OUT &&
		INTEG_OUT == INTEG_DEFAULT) else $error("configure preset wrong");
	chk_step_down: assert property (
		AUTORANGE_OUT && READING_VALID_IN && READING_PCT_IN < AR_DOWN_PCT &&
		RANGE_OUT != 3'h0 && !AVS_WRITE_IN ##1 !AVS_WRITE_IN |=>
		RANGE_OUT == $past(RANGE_OUT, 2) - 3'h1)
		else $error("no step down");
	chk_step_up: assert property (
		AUTORANGE_OUT && READING_VALID_IN && READING_PCT_IN > AR_UP_PCT &&
		RANGE_OUT < xp_rmax(FUNC_OUT) && !AVS_WRITE_IN ##1 !AVS_WRITE_IN
		|=> RANGE_OUT == $past(RANGE_OUT, 2) + 3'h1) else $error("no step up");
	chk_report_zero: assert property (
		REPORT_ZERO_OUT && $stable(FUNC_OUT) |->
		FUNC_OUT == 4'h7 || FUNC_OUT == 4'h8)
		else $error("zero report outside frequency and period");
	chk_highz_dcv: assert property (INPUT_HIGHZ_OUT &&
		$stable(FUNC_OUT) && $stable(RANGE_OUT) |->
		FUNC_OUT == 4'h0 && RANGE_OUT <= RANGE_HIGHZ_TOP)
		else $error("high input resistance on wrong range");
endmodule : mcms_config_asserts

bind mcms_config mcms_config_asserts #(.PCT_W(PCT_W)) mcms_config_asserts_i (
	.CLOCK_IN, .RST_B_IN, .AVS_ADDRESS_IN, .AVS_READ_IN, .AVS_WRITE_IN,
	.AVS_BYTEENABLE_IN, .AVS_WAITREQUEST_OUT, .READING_VALID_IN,
	.READING_PCT_IN, .WAIT_TRIG_ENTRY_IN, .FUNC_OUT, .RANGE_OUT,
	.AUTORANGE_OUT, .INTEG_OUT, .AUTOZERO_OUT, .ZERO_REQ_OUT,
	.INPUT_HIGHZ_OUT, .TEST_CURRENT_OUT, .REPORT_ZERO_OUT, .TRIG_IDLE_OUT,
	.MATH_OP_OUT, .MATH_ON_OUT);

// file: mcms_host.sv
`timescale 1ns/100ps
module mcms_host (
	// clock
	input wire logic clk_in,
	// answer from the slave
	input wire logic waitrequest_in,
	input wire logic [31:0] readdata_in,
	// request to the slave
	output logic [5:0] address_out,
	output logic read_out,
	output logic write_out,
	output logic [31:0] writedata_out,
	output logic [3:0] byteenable_out
);
	initial begin
		address_out = 6'h00;
		read_out = 1'b0;
		write_out = 1'b0;
		writedata_out = 32'h0;
		byteenable_out = 4'hF;
	end

	// function codes and resolution in units go out as plain words
	task wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge clk_in);
		address_out <= a;
		writedata_out <= d;
		byteenable_out <= b;
		write_out <= 1'b1;
		do @(posedge clk_in); while (waitrequest_in !== 1'b0);
		write_out <= 1'b0;
		writedata_out <= ~d;
	endtask : wr

	task rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clk_in);
		address_out <= a;
		read_out <= 1'b1;
		do @(posedge clk_in); while (waitrequest_in !== 1'b0);
		d = readdata_in;
		read_out <= 1'b0;
	endtask : rd
endmodule : mcms_host

// file: mcms_config_tb.sv
`timescale 1ns/100ps
module mcms_config_tb
	import mcms_pkg::*;
;
	`include "mcms_expect.svh"
	localparam logic [5:0] DADR [12] = '{REG_FUNC, REG_RANGE, REG_AUTORANGE,
		REG_RES, REG_INTEG, REG_GATE_FREQ, REG_GATE_PER, REG_AC_FILTER,
		REG_ZERO, REG_INPUT_R, REG_MATH_FUNC, REG_MATH_STATE};
	localparam logic [31:0] DVAL [12] = '{32'h0, 32'h4, 32'h1, 32'h64, 32'h3,
		32'h1, 32'h1, 32'h14, 32'h1, 32'h0, 32'h0, 32'h0};
	localparam logic [7:0] COR [4] = '{8'h09, 8'h0A, 8'h78, 8'h79};
	localparam logic [31:0] HZ [3] = '{32'h3, 32'h14, 32'hC8};
	logic clk, rst_b, rd, wr, wreq, vld, wte, sig, ar, az, zreq, hz, tcur;
	logic rz, tidle, mon;
	logic [5:0] adr;
	logic [31:0] wd, rdata, res, v;
	logic [3:0] be, func;
	logic [7:0] pct, p;
	logic [2:0] rng, integ, op, e;
	logic [1:0] gf, gp, acf;
	int num_errors, check_count, cyc;

	mcms_config #(.PCT_W(8)) mcms_config_i (.CLOCK_IN(clk), .RST_B_IN(rst_b),
		.AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
		.AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq),
		.READING_VALID_IN(vld), .READING_PCT_IN(pct),
		.WAIT_TRIG_ENTRY_IN(wte), .SIGNAL_PRESENT_IN(sig), .FUNC_OUT(func),
		.RANGE_OUT(rng), .AUTORANGE_OUT(ar), .RES_OUT(res), .INTEG_OUT(integ),
		.GATE_FREQ_OUT(gf), .GATE_PER_OUT(gp), .AC_FILTER_OUT(acf),
		.AUTOZERO_OUT(az), .ZERO_REQ_OUT(zreq), .INPUT_HIGHZ_OUT(hz),
		.TEST_CURRENT_OUT(tcur), .REPORT_ZERO_OUT(rz),
		.TRIG_IDLE_OUT(tidle), .MATH_OP_OUT(op), .MATH_ON_OUT(mon));
	mcms_host host_i (.clk_in(clk), .waitrequest_in(wreq),
		.readdata_in(rdata), .address_out(adr), .read_out(rd),
		.write_out(wr), .writedata_out(wd), .byteenable_out(be));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	// write, then let the outputs settle
	task w(input logic [5:0] a, input logic [31:0] d);
		host_i.wr(a, d, 4'hF);
		@(negedge clk);
	endtask : w

	task rc(input logic [5:0] a, input logic [31:0] x);
		host_i.rd(a, v);
		chk(v, x);
	endtask : rc

	// status bit check, then clear the sticky errors
	task st(input int b, input logic x);
		host_i.rd(REG_STATUS, v);
		chk(v[b], x);
		w(REG_STATUS, 32'h7);
	endtask : st

	task pulse_wte;
		@(posedge clk);
		wte <= 1'b1;
		@(posedge clk);
		wte <= 1'b0;
		@(negedge clk);
	endtask : pulse_wte

	task results;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
	end

	initial begin
		{rst_b, vld, wte, sig, pct} = '0;
		void'($urandom(32'hBC81));
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		foreach (DADR[i]) rc(DADR[i], DVAL[i]);
		rc(6'h3C, 32'h0);
		for (logic [3:0] f = 4'h0; f < 4'hB; f++) begin
			w(REG_FUNC, 32'(f));
			rc(REG_FUNC, 32'(f));
			chk(rng, xp_rmax(f));
			chk(tcur, f == 4'hA);
			w(REG_RANGE, 32'h0);
			chk(rng, f > 4'h8);
			w(REG_RANGE, 32'hFF);
			chk(rng, xp_rmax(f));
			w(REG_RES, 32'h5);
			chk(res, f > 4'h8 ? 32'h64 : 32'h5);
			if (f < 4'h9) st(1, f == 4'h1 || f == 4'h7 || f == 4'h8);
			for (logic [2:0] o = 3'h0; o < 3'h5; o++) begin
				w(REG_MATH_FUNC, 32'(o));
				w(REG_MATH_STATE, 32'h1);
				rc(REG_MATH_STATE, 32'(xp_ok(f, o)));
				w(REG_MATH_STATE, 32'h0);
			end
		end
		w(REG_FUNC, 32'(FN_FREQ));
		for (int g = 0; g < 3; g++) begin
			w(REG_GATE_FREQ, 32'(g));
			w(REG_GATE_PER, 32'(g));
			chk(gf, g);
			chk(gp, g);
			rc(REG_RES, g == 0 ? 32'h3E8 : g == 1 ? 32'h64 : 32'hA);
		end
		repeat (4) @(negedge clk);
		chk(rz, 1'b1);
		@(posedge clk);
		sig <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(rz, 1'b0);
		w(REG_FUNC, 32'(FN_DCI));
		w(REG_INTEG, 32'h0);
		w(REG_AUTORANGE, 32'h0);
		pulse_wte();
		chk(tidle, 1'b0);
		w(REG_CONF, 32'(FN_DCI));
		chk({tidle, ar, mon, integ, rng}, {3'b110, 3'h3, 3'h3});
		rc(REG_AUTORANGE, 32'h1);
		e = 3'h3;
		for (int i = 0; i < 24; i++) begin
			p = i < 4 ? COR[i] : 8'($urandom_range(200));
			@(posedge clk);
			vld <= 1'b1;
			pct <= p;
			@(posedge clk);
			vld <= 1'b0;
			repeat (2) @(posedge clk);
			@(negedge clk);
			if (p < 8'd10 && e > 3'h0) e--;
			else if (p > 8'd120 && e < 3'h3) e++;
			chk(rng, e);
		end
		for (int c = 0; c < 5; c++) begin
			w(REG_INTEG, 32'(c));
			chk(integ, c);
		end
		w(REG_RES, 32'h0);
		chk(res, 32'h1);
		w(REG_RES, 32'hFFFFFFFF);
		chk(res, 32'h2710);
		w(REG_FUNC, 32'(FN_ACV));
		w(REG_INTEG, 32'h1);
		st(1, 1'b1);
		for (int i = 0; i < 3; i++) begin
			w(REG_AC_FILTER, HZ[i]);
			chk(acf, i);
			rc(REG_AC_FILTER, HZ[i]);
		end
		w(REG_ZERO, 32'(AZ_OFF));
		rc(REG_ZERO, 32'h0);
		pulse_wte();
		chk(zreq, 1'b1);
		w(REG_ZERO, 32'(AZ_ONE_SHOT));
		chk({zreq, az}, 2'b10);
		rc(REG_ZERO, 32'h0);
		w(REG_ZERO, 32'(AZ_ON));
		rc(REG_ZERO, 32'h1);
		w(REG_FUNC, 32'(FN_DCV));
		w(REG_RANGE, 32'h0);
		w(REG_INPUT_R, 32'h1);
		chk(hz, 1'b1);
		rc(REG_INPUT_R, 32'h1);
		w(REG_RANGE, 32'h4);
		chk(hz, 1'b0);
		w(REG_FUNC, 32'(FN_DCI));
		w(REG_MATH_STATE, 32'h1);
		chk(mon, 1'b1);
		w(REG_MATH_FUNC, 32'(OP_DB));
		chk(mon, 1'b0);
		chk(op, 32'(OP_DB));
		st(0, 1'b1);
		host_i.wr(REG_INTEG, 32'h1, 4'h3);
		st(2, 1'b1);
		w(REG_RESET, 32'h1);
		foreach (DADR[i]) rc(DADR[i], DVAL[i]);
		results();
	end
endmodule : mcms_config_tb
